// *** dv/pbm_far_end.sv ***
// far-side model: external drivers on pins 4..7 and the resulting pin levels
`timescale 1ns/1ps
`default_nettype none
module pbm_far_end (
	// device side
	input  wire logic [3:0] pin_out,
	input  wire logic [3:0] pin_oe,
	// external drive, index 0 is bit 4
	input  wire logic [3:0] ext_val,
	// resolved levels
	output var  logic [3:0] pin_in
);
	// the outside party backs off wherever the device drives, so no contention is modelled
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pin_in[i] = pin_oe[i] ? pin_out[i] : ext_val[i];
		end
	end
endmodule
`default_nettype wire

// *** dv/port_b_upper_pin_mux_test.sv ***
// self-checking bench for the upper port pin mux
`timescale 1ns/1ps
`default_nettype none
module port_b_upper_pin_mux_test;
	import pbm_pkg::*;
	logic        clk;
	logic        reset_n;
	pbm_bus_t    bus;
	logic [7:0]  rdata;
	logic [3:0]  fuse_bits;
	pbm_periph_t periph;
	pbm_inputs_t to_periph;
	logic [3:0]  pin_in;
	logic [3:0]  pin_out;
	logic [3:0]  pin_oe;
	logic        irq;
	logic [3:0]  ext_val;
	int          err_total;
	int          checked;
	int          seed;
	logic [7:0]  d;
	logic [7:0]  rv;
	logic [7:0]  dir;
	logic [7:0]  an;
	logic [7:0]  lat;
	// address in the top nibble, reset value below; pins read assumes ext drive 4'hA
	logic [11:0] rst_tab [11] = '{12'h000, 12'h1FF, 12'h230, 12'h300, 12'h480, 12'h600,
		12'h700, 12'h900, 12'hA0F, 12'hB00, 12'hF00};

	pbm_port_mux i_dut (.clk(clk), .reset_n(reset_n), .bus(bus), .rdata(rdata),
		.fuse_bits(fuse_bits), .periph(periph), .to_periph(to_periph),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
	pbm_far_end i_far (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val), .pin_in(pin_in));

	always #20 clk = ~clk;

	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		bus <= '{a, v, 1'b1, 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask
	task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 rv = rdata;
		chk(rv, exp);
	endtask
	// sample away from the edge so registered outputs have settled
	task automatic look(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic drv(input logic [15:0] p, input logic [3:0] e);
		@(posedge clk);
		periph <= p;
		ext_val <= e;
	endtask
	task automatic do_reset(input logic [3:0] f);
		@(posedge clk);
		fuse_bits <= f;
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge clk);
	endtask
	function automatic logic [7:0] dig(input logic [7:0] dr, input logic [7:0] a,
		input logic [3:0] e);
		return {dr[7:4] & ~a[7:4] & e, 4'h0};
	endfunction
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		#2000000;
		err_total++;
		finish_test;
	end

	initial begin
		clk = 1'b0;
		reset_n = 1'b0;
		bus = '0;
		fuse_bits = 4'hF;
		periph = '0;
		ext_val = 4'hA;
		err_total = 0;
		checked = 0;
		seed = 32'h62d4;
		do_reset(4'hF);
		foreach (rst_tab[i]) rchk(rst_tab[i][11:8], rst_tab[i][7:0]);
		$display("test reset values done");
		for (int i = 0; i < 8; i++) begin
			d = $random(seed);
			wr(PBM_ADDR_ANSEL, d);
			wr(PBM_ADDR_IOC, d);
			wr(PBM_ADDR_SLEW, d);
			wr(PBM_ADDR_FUSE, d);
			rchk(PBM_ADDR_ANSEL, d & PBM_MASK_ANSEL);
			rchk(PBM_ADDR_IOC, d & PBM_MASK_UPPER);
			rchk(PBM_ADDR_SLEW, d & PBM_MASK_SLEW);
			rchk(PBM_ADDR_FUSE, PBM_RST_FUSE);
		end
		wr(PBM_ADDR_IOC, 8'h00);
		$display("test unimplemented bits done");
		for (int i = 0; i < 40; i++) begin
			dir = $random(seed);
			an = $random(seed);
			lat = $random(seed);
			drv(16'h0000, 4'($random(seed)));
			wr(PBM_ADDR_DIR, dir);
			wr(PBM_ADDR_ANSEL, an);
			wr(PBM_ADDR_LATCH, lat);
			look(3);
			chk(pin_oe, {4'h0, ~dir[7:4]});
			chk(pin_out & pin_oe, lat[7:4] & ~dir[7:4]);
			if (dir[4] && !an[4]) chk(to_periph.timer5_gate_in, ext_val[0]);
			if (dir[5] && !an[5]) chk(to_periph.timer1_gate_in, ext_val[1]);
			if (dir[5] && !an[5]) chk(to_periph.capcomp3_pin, ext_val[1]);
			if (dir[6]) chk(to_periph.serial2_sync_clock, ext_val[2]);
			if (dir[7]) chk({to_periph.serial2_sync_data, to_periph.serial2_async_rx},
				{2{ext_val[3]}});
			rchk(PBM_ADDR_PINS, dig(dir, an & PBM_MASK_ANSEL, ext_val));
		end
		$display("test direction and analog done");
		wr(PBM_ADDR_DIR, 8'h0F);
		wr(PBM_ADDR_LATCH, 8'hF0);
		// pwm1 d, pwm2 b, serial2 clock and data enabled with level 0 against a latch of ones
		drv(16'h4150, 4'h5);
		look(3);
		chk({pin_oe, pin_out}, 8'hF0);
		drv(16'h1C00, 4'h5);
		look(3);
		chk({pin_oe, pin_out}, 8'hFD);
		drv(16'h4158, 4'h5);
		look(3);
		chk({pin_oe, pin_out}, 8'hF8);
		drv(16'h4155, 4'h5);
		look(3);
		chk({pin_oe, pin_out[3], pin_out[1:0]}, 8'h58);
		drv(16'h4154, 4'hA);
		look(3);
		chk(pin_oe, 4'h3);
		chk({to_periph.prog_debug_clock, to_periph.prog_debug_data}, 2'b01);
		$display("test peripheral outputs done");
		drv(16'h0000, 4'h0);
		do_reset(4'h0);
		wr(PBM_ADDR_DIR, 8'h0F);
		wr(PBM_ADDR_LATCH, 8'hF0);
		drv(16'h1100, 4'h0);
		look(3);
		chk(pin_out[1], 1'b1);
		wr(PBM_ADDR_DIR, 8'hFF);
		wr(PBM_ADDR_ANSEL, 8'h00);
		drv(16'h0000, 4'h2);
		look(3);
		chk(to_periph.timer3_clock_in, 1'b1);
		$display("test relocation done");
		wr(PBM_ADDR_IOC, 8'h40);
		wr(PBM_ADDR_INTERRUPT_CONTROL_MAIN, 8'h08);
		look(3);
		wr(PBM_ADDR_INTERRUPT_CONTROL_MAIN, 8'h08);
		wr(PBM_ADDR_IRQ_ST, 8'hFF);
		drv(16'h0000, 4'h3);
		look(3);
		rchk(PBM_ADDR_INTERRUPT_CONTROL_MAIN, 8'h08);
		wr(PBM_ADDR_IRQ_ST, 8'hFF);
		look(3);
		chk(irq, 1'b0);
		drv(16'h0000, 4'h7);
		look(3);
		chk(irq, 1'b1);
		rchk(PBM_ADDR_INTERRUPT_CONTROL_MAIN, 8'h09);
		rchk(PBM_ADDR_IRQ_ST, 8'h04);
		wr(PBM_ADDR_INTERRUPT_CONTROL_MAIN, 8'h08);
		look(3);
		chk(irq, 1'b0);
		wr(PBM_ADDR_IRQ_MSK, 8'h04);
		look(3);
		chk(irq, 1'b1);
		wr(PBM_ADDR_IRQ_ST, 8'h04);
		look(3);
		chk(irq, 1'b0);
		rchk(PBM_ADDR_IRQ_ST, 8'h00);
		$display("test change interrupt done");
		finish_test;
	end
endmodule
`default_nettype wire

// *** src/pbm_pkg.sv ***
// package: register map, field positions, reset values and carrier types for the port pin mux
package pbm_pkg;
// Summary of operation
// (RULE1) direction 0 drives the pin from the output latch, analog select ignored.
// (RULE2) digital input works only with direction 1 and analog select 0.
// (RULE3) relocation fuses set: pwm2b, timer3 clock, capcomp3, capcomp2 stay on default pins.
// (RULE4) fuse cleared moves its function to the alternate pin; timer3 clock reaches bit 5.
// (RULE5) bit 4 carries pwm1 output d as output and timer5 gate as input.
// (RULE6) bit 5 carries capcomp3 compare output or its capture input.
// (RULE7) bit 5 supplies the timer1 gate when it is a digital input.
// (RULE8) bit 6 carries serial2 sync clock: out when direction 0, in when 1.
// (RULE9) bit 7 carries serial2 sync data; async mode rx on 7, tx on 6.
// (RULE10) bits 6 and 7 serve the debug clock and data regardless of settings.
// (RULE11) unimplemented register bits read as zero.
// (RULE12) enabled level change on bits 4..7 sets port change flag; irq if enabled.
	localparam logic [3:0] PBM_ADDR_LATCH   = 4'h0;
	localparam logic [3:0] PBM_ADDR_DIR     = 4'h1;
	localparam logic [3:0] PBM_ADDR_ANSEL   = 4'h2;
	localparam logic [3:0] PBM_ADDR_IOC     = 4'h3;
	localparam logic [3:0] PBM_ADDR_PINS    = 4'h4;
	localparam logic [3:0] PBM_ADDR_INTERRUPT_CONTROL_MAIN  = 4'h5;
	localparam logic [3:0] PBM_ADDR_WPU     = 4'h6;
	localparam logic [3:0] PBM_ADDR_SLEW    = 4'h7;
	localparam logic [3:0] PBM_ADDR_IRQ_ST  = 4'h8;
	localparam logic [3:0] PBM_ADDR_IRQ_MSK = 4'h9;
	localparam logic [3:0] PBM_ADDR_FUSE    = 4'hA;
	// implemented bit masks
	localparam logic [7:0] PBM_MASK_UPPER   = 8'hF0;
	localparam logic [7:0] PBM_MASK_ANSEL   = 8'h30;
	localparam logic [7:0] PBM_MASK_SLEW    = 8'h1F;
	localparam logic [7:0] PBM_MASK_INTERRUPT_CONTROL_MAIN  = 8'h09;
	localparam logic [7:0] PBM_MASK_FUSE    = 8'h0F;
	// field positions
	localparam int PBM_BIT_FLAG    = 0;
	localparam int PBM_BIT_IE      = 3;
	localparam int PBM_FUSE_CCP2   = 0;
	localparam int PBM_FUSE_CAPCOMP3_PIN   = 1;
	localparam int PBM_FUSE_T3C    = 2;
	localparam int PBM_FUSE_PB2    = 3;
	// reset values
	localparam logic [7:0] PBM_RST_LATCH = 8'h00;
	localparam logic [7:0] PBM_RST_DIR   = 8'hFF;
	localparam logic [7:0] PBM_RST_ANSEL = 8'h30;
	localparam logic [7:0] PBM_RST_ZERO  = 8'h00;
	localparam logic [7:0] PBM_RST_FUSE  = 8'h0F;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} pbm_bus_t;

	// peripheral output side (each with an enable: the peripheral replaces the latch value, direction sets the drive except on bits 6 and 7 while debug_active)
	typedef struct packed {
		logic pwm1_output_d;
		logic pwm1_d_en;
		logic capcomp3_out;
		logic capcomp3_en;
		logic pwm3_output_a;
		logic pwm3_a_en;
		logic pwm2_output_b;
		logic pwm2_b_en;
		logic serial2_clk_out;
		logic serial2_clk_en;
		logic serial2_data_out;
		logic serial2_data_en;
		logic serial2_async;
		logic debug_active;
		logic debug_data_out;
		logic debug_data_oe;
	} pbm_periph_t;

	typedef struct packed {
		logic timer5_gate_in;
		logic timer1_gate_in;
		logic capcomp3_pin;
		logic timer3_clock_in;
		logic serial2_sync_clock;
		logic serial2_sync_data;
		logic serial2_async_rx;
		logic prog_debug_clock;
		logic prog_debug_data;
	} pbm_inputs_t;
endpackage

// *** src/pbm_port_mux.sv ***
// module: upper port pins 4..7 with pin muxing, registers and change interrupt
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module pbm_port_mux (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                reset_n,
	// register port
	input  wire pbm_pkg::pbm_bus_t   bus,
	output var  logic [7:0]          rdata,
	// configuration fuses, static
	input  wire logic [3:0]          fuse_bits,
	// peripheral side
	input  wire pbm_pkg::pbm_periph_t periph,
	output var  pbm_pkg::pbm_inputs_t to_periph,
	// pins 4..7
	input  wire logic [3:0]          pin_in,
	output var  logic [3:0]          pin_out,
	output var  logic [3:0]          pin_oe,
	// interrupt
	output var  logic                irq
);
	import pbm_pkg::*;

	logic [7:0] latch_reg;
	logic [7:0] dir_reg;
	logic [7:0] ansel_reg;
	logic [7:0] ioc_reg;
	logic [7:0] wpu_reg;
	logic [7:0] slew_reg;
	logic       ie_reg;
	logic       flag_reg;
	logic [3:0] sts_reg;
	logic [3:0] msk_reg;
	logic [3:0] fuse_reg;
	logic [3:0] last_reg;
	logic [3:0] dig_in;
	logic [3:0] change;
	logic [3:0] out_next;
	logic [3:0] oe_next;

	function automatic logic dig_ok(input logic d, input logic a);
		return d && !a;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// fuses caught after reset release, never by the async reset
	logic fuse_taken_reg;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			fuse_reg       <= PBM_RST_FUSE[3:0];
			fuse_taken_reg <= 1'b0;
		end else if (!fuse_taken_reg) begin
			fuse_reg       <= fuse_bits;
			fuse_taken_reg <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// digital input gating
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			dig_in[i] = dig_ok(dir_reg[i+4], ansel_reg[i+4]) & pin_in[i]; // [RULE2]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// output drive; peripherals outrank the latch, debug outranks all on bits 6 and 7
	always_comb begin
		oe_next  = ~dir_reg[7:4]; // [RULE1]
		out_next = latch_reg[7:4]; // [RULE1]
		if (periph.pwm1_d_en && !dir_reg[4]) begin
			out_next[0] = periph.pwm1_output_d; // [RULE5]
		end
		if (!dir_reg[5]) begin
			if (periph.capcomp3_en && fuse_reg[PBM_FUSE_CAPCOMP3_PIN]) begin
				out_next[1] = periph.capcomp3_out; // [RULE6] [RULE3]
			end else if (periph.pwm3_a_en && fuse_reg[PBM_FUSE_CAPCOMP3_PIN]) begin
				out_next[1] = periph.pwm3_output_a; // [RULE3]
			end else if (periph.pwm2_b_en && fuse_reg[PBM_FUSE_PB2]) begin
				out_next[1] = periph.pwm2_output_b; // [RULE3]
			end
		end
		if (periph.serial2_clk_en && !dir_reg[6]) begin
			out_next[2] = periph.serial2_clk_out; // [RULE8] [RULE9]
		end
		if (periph.serial2_data_en && !dir_reg[7] && !periph.serial2_async) begin
			out_next[3] = periph.serial2_data_out; // [RULE9]
		end
		if (periph.debug_active) begin
			oe_next[2]  = 1'b0; // [RULE10]
			oe_next[3]  = periph.debug_data_oe; // [RULE10]
			out_next[3] = periph.debug_data_out; // [RULE10]
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_out <= 4'h0;
			pin_oe  <= 4'h0;
		end else begin
			pin_out <= out_next;
			pin_oe  <= oe_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// peripheral inputs, registered
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			to_periph <= '0;
		end else begin
			to_periph.timer5_gate_in     <= dig_in[0]; // [RULE5]
			to_periph.capcomp3_pin       <= fuse_reg[PBM_FUSE_CAPCOMP3_PIN] & dig_in[1]; // [RULE6]
			to_periph.timer1_gate_in     <= dig_in[1]; // [RULE7]
			to_periph.timer3_clock_in    <= !fuse_reg[PBM_FUSE_T3C] & dig_in[1]; // [RULE4]
			to_periph.serial2_sync_clock <= dig_in[2]; // [RULE8]
			to_periph.serial2_sync_data  <= dig_in[3]; // [RULE9]
			to_periph.serial2_async_rx   <= dig_in[3]; // [RULE9]
			to_periph.prog_debug_clock   <= pin_in[2]; // [RULE10]
			to_periph.prog_debug_data    <= pin_in[3]; // [RULE10]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registers
	logic wr_st;
	assign wr_st = bus.wr && bus.addr == PBM_ADDR_IRQ_ST;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			latch_reg <= PBM_RST_LATCH;
			dir_reg   <= PBM_RST_DIR;
			ansel_reg <= PBM_RST_ANSEL;
			ioc_reg   <= PBM_RST_ZERO;
			wpu_reg   <= PBM_RST_ZERO;
			slew_reg  <= PBM_RST_ZERO;
			ie_reg    <= 1'b0;
			msk_reg   <= 4'h0;
		end else if (bus.wr) begin
			case (bus.addr)
				PBM_ADDR_LATCH:   latch_reg <= bus.wdata;
				PBM_ADDR_PINS:    latch_reg <= bus.wdata;
				PBM_ADDR_DIR:     dir_reg   <= bus.wdata;
				PBM_ADDR_ANSEL:   ansel_reg <= bus.wdata & PBM_MASK_ANSEL; // [RULE11]
				PBM_ADDR_IOC:     ioc_reg   <= bus.wdata & PBM_MASK_UPPER; // [RULE11]
				PBM_ADDR_WPU:     wpu_reg   <= bus.wdata;
				PBM_ADDR_SLEW:    slew_reg  <= bus.wdata & PBM_MASK_SLEW; // [RULE11]
				PBM_ADDR_INTERRUPT_CONTROL_MAIN:  ie_reg    <= bus.wdata[PBM_BIT_IE];
				PBM_ADDR_IRQ_MSK: msk_reg   <= bus.wdata[3:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// change detect: set wins over a clear in the same cycle
	assign change = (last_reg ^ dig_in) & ioc_reg[7:4];
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			last_reg <= 4'h0;
			flag_reg <= 1'b0;
			sts_reg  <= 4'h0;
		end else begin
			last_reg <= dig_in;
			if (|change) begin
				flag_reg <= 1'b1; // [RULE12]
			end else if (bus.wr && bus.addr == PBM_ADDR_INTERRUPT_CONTROL_MAIN && !bus.wdata[PBM_BIT_FLAG]) begin
				flag_reg <= 1'b0;
			end
			sts_reg <= (sts_reg & ~(wr_st ? bus.wdata[3:0] : 4'h0)) | change; // [RULE12]
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq <= 1'b0;
		end else begin
			irq <= (|(sts_reg & msk_reg)) | (flag_reg & ie_reg); // [RULE12]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read path, one cycle later; unmapped reads zero
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata <= 8'h00;
		end else if (bus.rd) begin
			case (bus.addr)
				PBM_ADDR_LATCH:   rdata <= latch_reg;
				PBM_ADDR_DIR:     rdata <= dir_reg;
				PBM_ADDR_ANSEL:   rdata <= ansel_reg; // [RULE11]
				PBM_ADDR_IOC:     rdata <= ioc_reg; // [RULE11]
				PBM_ADDR_PINS:    rdata <= {dig_in, 4'h0};
				PBM_ADDR_INTERRUPT_CONTROL_MAIN:  rdata <= {4'h0, ie_reg, 2'b00, flag_reg};
				PBM_ADDR_WPU:     rdata <= wpu_reg;
				PBM_ADDR_SLEW:    rdata <= slew_reg;
				PBM_ADDR_IRQ_ST:  rdata <= {4'h0, sts_reg};
				PBM_ADDR_IRQ_MSK: rdata <= {4'h0, msk_reg};
				PBM_ADDR_FUSE:    rdata <= {4'h0, fuse_reg};
				default:          rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	property p_latch_drive;
		@(posedge clk) disable iff (!reset_n)
		(!dir_reg[4] && !periph.pwm1_d_en && !periph.debug_active) |=>
			(pin_oe[0] && pin_out[0] == $past(latch_reg[4]));
	endproperty
	a_latch_drive: assert property (p_latch_drive) else $error("latch not driven"); // [RULE1]

	property p_analog_block;
		@(posedge clk) disable iff (!reset_n)
		ansel_reg[4] |=> !to_periph.timer5_gate_in;
	endproperty
	a_analog_block: assert property (p_analog_block) else $error("analog pin fed input"); // [RULE2]

	property p_t3_alt;
		@(posedge clk) disable iff (!reset_n)
		fuse_reg[PBM_FUSE_T3C] |=> !to_periph.timer3_clock_in;
	endproperty
	a_t3_alt: assert property (p_t3_alt) else $error("timer3 clock with fuse set"); // [RULE4]

	property p_t1_gate;
		@(posedge clk) disable iff (!reset_n)
		1'b1 |=> to_periph.timer1_gate_in == $past(dir_reg[5] && !ansel_reg[5] && pin_in[1]);
	endproperty
	a_t1_gate: assert property (p_t1_gate) else $error("timer1 gate mismatch"); // [RULE7]

	property p_debug_clk;
		@(posedge clk) disable iff (!reset_n)
		periph.debug_active |=> !pin_oe[2];
	endproperty
	a_debug_clk: assert property (p_debug_clk) else $error("debug clock pin driven"); // [RULE10]

	property p_ioc_zero;
		@(posedge clk) disable iff (!reset_n)
		(bus.rd && bus.addr == PBM_ADDR_IOC) |=> rdata[3:0] == 4'h0;
	endproperty
	a_ioc_zero: assert property (p_ioc_zero) else $error("ioc low bits nonzero"); // [RULE11]

	sequence s_change;
		|change;
	endsequence
	property p_flag_set;
		@(posedge clk) disable iff (!reset_n)
		s_change |=> flag_reg ##1 (irq || !$past(ie_reg));
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("change flag lost"); // [RULE12]

	property p_clk_out;
		@(posedge clk) disable iff (!reset_n)
		(periph.serial2_clk_en && !dir_reg[6] && !periph.debug_active) |=>
			(pin_oe[2] && pin_out[2] == $past(periph.serial2_clk_out));
	endproperty
	a_clk_out: assert property (p_clk_out) else $error("serial clock not driven"); // [RULE8]

	property p_dir_drive;
		@(posedge clk) disable iff (!reset_n)
		!periph.debug_active |=> pin_oe == ~$past(dir_reg[7:4]);
	endproperty
	a_dir_drive: assert property (p_dir_drive) else $error("pin enable wrong"); // [RULE1]

	property p_t5_gate;
		@(posedge clk) disable iff (!reset_n)
		1'b1 |=> to_periph.timer5_gate_in == $past(dir_reg[4] && !ansel_reg[4] && pin_in[0]);
	endproperty
	a_t5_gate: assert property (p_t5_gate) else $error("timer5 gate wrong"); // [RULE5]

	property p_capcomp3_pin_in;
		@(posedge clk) disable iff (!reset_n)
		fuse_reg[PBM_FUSE_CAPCOMP3_PIN] |=>
			to_periph.capcomp3_pin == $past(dir_reg[5] && !ansel_reg[5] && pin_in[1]);
	endproperty
	a_capcomp3_pin_in: assert property (p_capcomp3_pin_in) else $error("capture input wrong"); // [RULE6]

	property p_capcomp3_pin_out;
		@(posedge clk) disable iff (!reset_n)
		(!dir_reg[5] && periph.capcomp3_en && fuse_reg[PBM_FUSE_CAPCOMP3_PIN]) |=>
			pin_out[1] == $past(periph.capcomp3_out);
	endproperty
	a_capcomp3_pin_out: assert property (p_capcomp3_pin_out) else $error("compare output wrong"); // [RULE6]

	// with both bit-5 relocation fuses cleared, only the latch may reach the pin
	property p_pwm2b_alt;
		@(posedge clk) disable iff (!reset_n)
		(!dir_reg[5] && !fuse_reg[PBM_FUSE_PB2] && !fuse_reg[PBM_FUSE_CAPCOMP3_PIN]) |=>
			pin_out[1] == $past(latch_reg[5]);
	endproperty
	a_pwm2b_alt: assert property (p_pwm2b_alt) else $error("bit 5 not latch"); // [RULE4]

	property p_pwm1d_out;
		@(posedge clk) disable iff (!reset_n)
		(!dir_reg[4] && periph.pwm1_d_en) |=>
			pin_oe[0] && pin_out[0] == $past(periph.pwm1_output_d);
	endproperty
	a_pwm1d_out: assert property (p_pwm1d_out) else $error("pwm output d wrong"); // [RULE5]

	property p_sync_clk_in;
		@(posedge clk) disable iff (!reset_n)
		1'b1 |=> to_periph.serial2_sync_clock ==
			$past(dir_reg[6] && !ansel_reg[6] && pin_in[2]);
	endproperty
	a_sync_clk_in: assert property (p_sync_clk_in) else $error("clock input wrong"); // [RULE8]

	property p_data_out;
		@(posedge clk) disable iff (!reset_n)
		(periph.serial2_data_en && !dir_reg[7] && !periph.serial2_async && !periph.debug_active)
			|=> pin_oe[3] && pin_out[3] == $past(periph.serial2_data_out);
	endproperty
	a_data_out: assert property (p_data_out) else $error("data out wrong"); // [RULE9]

	property p_async_rx;
		@(posedge clk) disable iff (!reset_n)
		1'b1 |=> to_periph.serial2_async_rx ==
			$past(dir_reg[7] && !ansel_reg[7] && pin_in[3]);
	endproperty
	a_async_rx: assert property (p_async_rx) else $error("receive input wrong"); // [RULE9]

	property p_async_latch;
		@(posedge clk) disable iff (!reset_n)
		(periph.serial2_async && !periph.debug_active && !dir_reg[7]) |=>
			pin_oe[3] && pin_out[3] == $past(latch_reg[7]);
	endproperty
	a_async_latch: assert property (p_async_latch) else $error("bit 7 not latch"); // [RULE9]

	property p_debug_data;
		@(posedge clk) disable iff (!reset_n)
		periph.debug_active |=> pin_oe[3] == $past(periph.debug_data_oe) &&
			pin_out[3] == $past(periph.debug_data_out);
	endproperty
	a_debug_data: assert property (p_debug_data) else $error("debug data wrong"); // [RULE10]

	property p_debug_in;
		@(posedge clk) disable iff (!reset_n)
		1'b1 |=> {to_periph.prog_debug_clock, to_periph.prog_debug_data} ==
			$past({pin_in[2], pin_in[3]});
	endproperty
	a_debug_in: assert property (p_debug_in) else $error("debug inputs wrong"); // [RULE10]

	property p_ansel_zero;
		@(posedge clk) disable iff (!reset_n)
		(bus.rd && bus.addr == PBM_ADDR_ANSEL) |=> (rdata & ~PBM_MASK_ANSEL) == 8'h00;
	endproperty
	a_ansel_zero: assert property (p_ansel_zero) else $error("analog bits nonzero"); // [RULE11]

	sequence s_status_clear;
		wr_st && |bus.wdata[3:0];
	endsequence
	property p_sts_clear;
		@(posedge clk) disable iff (!reset_n)
		s_status_clear |=> (sts_reg & $past(bus.wdata[3:0] & ~change)) == 4'h0;
	endproperty
	a_sts_clear: assert property (p_sts_clear) else $error("status not cleared"); // [RULE12]

	property p_sts_set;
		@(posedge clk) disable iff (!reset_n)
		s_change |=> (sts_reg & $past(change)) == $past(change);
	endproperty
	a_sts_set: assert property (p_sts_set) else $error("status bit not set"); // [RULE12]

	sequence s_flag_clear;
		bus.wr && bus.addr == PBM_ADDR_INTERRUPT_CONTROL_MAIN && !bus.wdata[PBM_BIT_FLAG] && !(|change);
	endsequence
	property p_flag_clear;
		@(posedge clk) disable iff (!reset_n)
		s_flag_clear |=> !flag_reg;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared"); // [RULE12]

	property p_irq_on;
		@(posedge clk) disable iff (!reset_n)
		(|(sts_reg & msk_reg)) |=> irq;
	endproperty
	a_irq_on: assert property (p_irq_on) else $error("unmasked status without irq"); // [RULE12]

	property p_irq_off;
		@(posedge clk) disable iff (!reset_n)
		(sts_reg & msk_reg) == 4'h0 && !(flag_reg && ie_reg) |=> !irq;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq without cause"); // [RULE12]
endmodule
`default_nettype wire
